// ==== inc/pcsi_defs.svh ====
// offsets, field positions and reset values of the program counter unit
`ifndef PCSI_DEFS_SVH
`define PCSI_DEFS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define PCSI_OFF_PCLOW      8'h00
`define PCSI_OFF_PCHIGH     8'h04
`define PCSI_OFF_FSEL       8'h08
`define PCSI_OFF_BANK       8'h0C
`define PCSI_OFF_PCFULL     8'h10

// ************************************************************
// field positions and widths
// ************************************************************
`define PCSI_PC_W           13
`define PCSI_JUMP_W         11
`define PCSI_HI_FULL_MSB    4
`define PCSI_HI_PAGE_LSB    3
`define PCSI_BANK_IND_BIT   7
`define PCSI_BANK_DIR_HI    6
`define PCSI_BANK_DIR_LO    5

// ************************************************************
// reset values and interrupt vector
// ************************************************************
`define PCSI_RST_PC         13'h0000
`define PCSI_RST_BYTE       8'h00
`define PCSI_IRQ_VECTOR     13'h0004

`endif

// ==== inc/pcsi_pkg.sv ====
// types shared by the program counter unit and its users
package pcsi_pkg;

    // ************************************************************
    // flow operations from instruction decode
    // ************************************************************
    typedef enum logic [2:0] {
        PCSI_OP_STEP    = 3'b000,
        PCSI_OP_JUMP    = 3'b001,
        PCSI_OP_CALL    = 3'b010,
        PCSI_OP_RET     = 3'b011,
        PCSI_OP_IRQ     = 3'b100,
        PCSI_OP_LOWWR   = 3'b101,
        PCSI_OP_LOWADD  = 3'b110
    } pcsi_op_t;

    typedef struct packed {
        logic           valid;
        pcsi_op_t       op;
        logic [10:0]    target;
        logic [7:0]     data;
    } pcsi_flow_req_t;

    // ************************************************************
    // data address request and result
    // ************************************************************
    typedef struct packed {
        logic           indirect;
        logic [6:0]     location;
    } pcsi_daddr_req_t;

    typedef struct packed {
        logic [8:0]     addr;
        logic           read_zero;
        logic           write_block;
    } pcsi_daddr_t;

    typedef enum logic [1:0] {
        PCSI_BUS_IDLE   = 2'b00,
        PCSI_BUS_WRITE  = 2'b01,
        PCSI_BUS_RESP   = 2'b10
    } pcsi_wstate_t;

endpackage

// ==== verilog/pcsi_core.sv ====
// program counter, return stack and data addressing unit with axi4-lite registers
//
// Behaviour
// - program counter is thirteen bits wide
// - low counter byte is read/write; upper bits only loaded from high latch
// - writing the low byte also loads upper five bits from high latch
// - call or jump takes the top two counter bits from high latch bits 4:3
// - any reset clears the whole program counter
// - adding to the low byte never carries into the upper bits
// - return stack holds eight entries of thirteen bits
// - stack sits outside all spaces; its pointer is invisible to software
// - call and interrupt vectoring push the counter
// - return pops the top stack entry into the counter
// - push and pop leave the high latch untouched
// - stack wraps circularly; ninth push overwrites first entry
// - no overflow or underflow status exists
// - indirect port has no storage; it reaches the pointed location
// - indirect port reached indirectly reads as zero
// - indirect port reached indirectly stores nothing
// - indirect address is bank bit above eight-bit pointer
`timescale 1ns/1ps
`include "pcsi_defs.svh"

module pcsi_core #(
    parameter int STACK_DEPTH = 8,
    parameter int PTR_W       = 3
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       s_axi_awvalid,
    output      logic                       s_axi_awready,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output      logic                       s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output      logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output      logic [1:0]                 s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output      logic                       s_axi_arready,
    input  wire logic [7:0]                 s_axi_araddr,
    output      logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output      logic [31:0]                s_axi_rdata,
    output      logic [1:0]                 s_axi_rresp,
    input  wire pcsi_pkg::pcsi_flow_req_t   flow_req,
    output      logic [12:0]                pc_value,
    input  wire pcsi_pkg::pcsi_daddr_req_t  daddr_req,
    output      pcsi_pkg::pcsi_daddr_t      daddr
);

    // ************************************************************
    // state
    // ************************************************************
    logic [12:0]                pc_ff;
    logic [12:0]                nxt_pc;
    logic [7:0]                 pc_high_latch_ff;
    logic [7:0]                 file_select_pointer_ff;
    logic                       indirect_bank_bit_ff;
    logic                       direct_bank_select_hi_ff;
    logic                       direct_bank_select_lo_ff;
    logic [12:0]                stack_ff [STACK_DEPTH];
    logic [PTR_W-1:0]           sp_ff;
    logic [PTR_W-1:0]           nxt_sp;
    logic                       push;
    logic                       pop;
    logic [12:0]                push_value;

    pcsi_pkg::pcsi_wstate_t     wstate_ff;
    logic                       aw_held_ff;
    logic                       w_held_ff;
    logic [7:0]                 waddr_ff;
    logic [31:0]                wdata_ff;
    logic [3:0]                 wstrb_ff;
    logic [1:0]                 bresp_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 rresp_ff;

    // ************************************************************
    // helpers
    // ************************************************************
    // upper bits for a low-byte load: all five from the latch
    function automatic logic [12:0] low_load(input logic [7:0] hi, input logic [7:0] lo);
        low_load = {hi[`PCSI_HI_FULL_MSB:0], lo};
    endfunction

    function automatic logic [1:0] map_resp(input logic hit);
        map_resp = hit ? 2'h0 : 2'h2;
    endfunction

    // ************************************************************
    // flow decode
    // ************************************************************
    wire        op_valid    = flow_req.valid;
    wire        op_step     = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_STEP);
    wire        op_jump     = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_JUMP);
    wire        op_call     = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_CALL);
    wire        op_ret      = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_RET);
    wire        op_irq      = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_IRQ);
    wire        op_lowwr    = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_LOWWR);
    wire        op_lowadd   = op_valid && (flow_req.op == pcsi_pkg::PCSI_OP_LOWADD);
    wire [12:0] pc_plus1    = pc_ff + 13'h0001;
    wire [12:0] far_target  = {pc_high_latch_ff[`PCSI_HI_FULL_MSB:`PCSI_HI_PAGE_LSB],
                               flow_req.target};
    wire [7:0]  low_sum     = pc_ff[7:0] + flow_req.data;
    wire [PTR_W-1:0] sp_dec = sp_ff - {{(PTR_W-1){1'b0}}, 1'b1};

    // ************************************************************
    // axi write side
    // ************************************************************
    // software writes wait while the core moves the counter, so neither is lost
    wire        wr_fire     = (wstate_ff == pcsi_pkg::PCSI_BUS_WRITE) && !op_valid;
    wire        wr_lane0    = wstrb_ff[0];
    wire        hit_pclow   = (waddr_ff == `PCSI_OFF_PCLOW);
    wire        hit_pchigh  = (waddr_ff == `PCSI_OFF_PCHIGH);
    wire        hit_fsel    = (waddr_ff == `PCSI_OFF_FSEL);
    wire        hit_bank    = (waddr_ff == `PCSI_OFF_BANK);
    wire        hit_pcfull  = (waddr_ff == `PCSI_OFF_PCFULL);
    wire        wr_hit      = hit_pclow || hit_pchigh || hit_fsel || hit_bank || hit_pcfull;
    wire        sw_low_wr   = wr_fire && hit_pclow && wr_lane0;

    assign s_axi_awready = (wstate_ff == pcsi_pkg::PCSI_BUS_IDLE) && !aw_held_ff;
    assign s_axi_wready  = (wstate_ff == pcsi_pkg::PCSI_BUS_IDLE) && !w_held_ff;
    assign s_axi_bvalid  = (wstate_ff == pcsi_pkg::PCSI_BUS_RESP);
    assign s_axi_bresp   = bresp_ff;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_ff || aw_take;
    wire w_have  = w_held_ff || w_take;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wstate_ff  <= pcsi_pkg::PCSI_BUS_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            waddr_ff   <= 8'h00;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bresp_ff   <= 2'h0;
        end
        else
        begin
            case (wstate_ff)
                pcsi_pkg::PCSI_BUS_IDLE:
                begin
                    if (aw_take)
                    begin
                        waddr_ff   <= s_axi_awaddr;
                        aw_held_ff <= 1'b1;
                    end
                    if (w_take)
                    begin
                        wdata_ff  <= s_axi_wdata;
                        wstrb_ff  <= s_axi_wstrb;
                        w_held_ff <= 1'b1;
                    end
                    if (aw_have && w_have)
                    begin
                        wstate_ff <= pcsi_pkg::PCSI_BUS_WRITE;
                    end
                end
                pcsi_pkg::PCSI_BUS_WRITE:
                begin
                    if (!op_valid)
                    begin
                        bresp_ff   <= map_resp(wr_hit);
                        aw_held_ff <= 1'b0;
                        w_held_ff  <= 1'b0;
                        wstate_ff  <= pcsi_pkg::PCSI_BUS_RESP;
                    end
                end
                pcsi_pkg::PCSI_BUS_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wstate_ff <= pcsi_pkg::PCSI_BUS_IDLE;
                    end
                end
                default:
                begin
                    wstate_ff <= pcsi_pkg::PCSI_BUS_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    // full counter word is read-only; the stack pointer has no address at all
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc_high_latch_ff         <= `PCSI_RST_BYTE;
            file_select_pointer_ff   <= `PCSI_RST_BYTE;
            indirect_bank_bit_ff     <= 1'b0;
            direct_bank_select_hi_ff <= 1'b0;
            direct_bank_select_lo_ff <= 1'b0;
        end
        else if (wr_fire && wr_lane0)
        begin
            if (hit_pchigh)
            begin
                pc_high_latch_ff <= wdata_ff[7:0];
            end
            else if (hit_fsel)
            begin
                file_select_pointer_ff <= wdata_ff[7:0];
            end
            else if (hit_bank)
            begin
                indirect_bank_bit_ff     <= wdata_ff[`PCSI_BANK_IND_BIT];
                direct_bank_select_hi_ff <= wdata_ff[`PCSI_BANK_DIR_HI];
                direct_bank_select_lo_ff <= wdata_ff[`PCSI_BANK_DIR_LO];
            end
        end
    end

    // ************************************************************
    // program counter and return stack
    // ************************************************************
    assign push       = op_call || op_irq;
    assign pop        = op_ret;
    assign push_value = op_call ? pc_plus1 : pc_ff;
    // pointer just wraps; nothing records overflow or underflow
    assign nxt_sp     = push ? sp_ff + {{(PTR_W-1){1'b0}}, 1'b1} : (pop ? sp_dec : sp_ff);

    always_comb
    begin
        nxt_pc = pc_ff;
        if (op_step)
        begin
            nxt_pc = pc_plus1;
        end
        else if (op_jump || op_call)
        begin
            nxt_pc = far_target;
        end
        else if (op_ret)
        begin
            nxt_pc = stack_ff[sp_dec];
        end
        else if (op_irq)
        begin
            nxt_pc = `PCSI_IRQ_VECTOR;
        end
        else if (op_lowwr)
        begin
            nxt_pc = low_load(pc_high_latch_ff, flow_req.data);
        end
        else if (op_lowadd)
        begin
            nxt_pc = low_load(pc_high_latch_ff, low_sum);
        end
        else if (sw_low_wr)
        begin
            nxt_pc = low_load(pc_high_latch_ff, wdata_ff[7:0]);
        end
    end

    // high latch is written only by software above, never by push or pop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc_ff <= `PCSI_RST_PC;
            sp_ff <= '0;
        end
        else
        begin
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
        end
    end

    // storage is not cleared at reset; stale entries are simply overwritten
    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            stack_ff[sp_ff] <= push_value;
        end
    end

    assign pc_value = pc_ff;

    // ************************************************************
    // axi read side
    // ************************************************************
    wire       rd_pclow  = (s_axi_araddr == `PCSI_OFF_PCLOW);
    wire       rd_pchigh = (s_axi_araddr == `PCSI_OFF_PCHIGH);
    wire       rd_fsel   = (s_axi_araddr == `PCSI_OFF_FSEL);
    wire       rd_bank   = (s_axi_araddr == `PCSI_OFF_BANK);
    wire       rd_pcfull = (s_axi_araddr == `PCSI_OFF_PCFULL);
    wire       rd_hit    = rd_pclow || rd_pchigh || rd_fsel || rd_bank || rd_pcfull;
    wire [7:0] bank_word = {indirect_bank_bit_ff, direct_bank_select_hi_ff,
                            direct_bank_select_lo_ff, 5'h00};
    wire [31:0] rd_word  = rd_pclow  ? {24'h000000, pc_ff[7:0]} :
                           rd_pchigh ? {24'h000000, pc_high_latch_ff} :
                           rd_fsel   ? {24'h000000, file_select_pointer_ff} :
                           rd_bank   ? {24'h000000, bank_word} :
                           rd_pcfull ? {19'h00000, pc_ff} : 32'h00000000;

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= 2'h0;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= map_resp(rd_hit);
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // data addressing
    // ************************************************************
    // pointer at location zero of any bank is the port itself: no storage behind it
    wire ind_self = daddr_req.indirect && (file_select_pointer_ff[6:0] == 7'h00);

    assign daddr.addr        = daddr_req.indirect
                             ? {indirect_bank_bit_ff, file_select_pointer_ff}
                             : {direct_bank_select_hi_ff, direct_bank_select_lo_ff,
                                daddr_req.location};
    assign daddr.read_zero   = ind_self;
    assign daddr.write_block = ind_self;

endmodule // pcsi_core

// ==== test/pcsi_core_props.sv ====
// concurrent checks on the program counter unit ports
`timescale 1ns/1ps
`include "pcsi_defs.svh"
module pcsi_core_props (
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire pcsi_pkg::pcsi_flow_req_t  flow_req,
    input wire logic [12:0]               pc_value,
    input wire pcsi_pkg::pcsi_daddr_req_t daddr_req,
    input wire pcsi_pkg::pcsi_daddr_t     daddr
);
    // ************************************************************
    // decoded requests
    // ************************************************************
    wire logic v_op   = flow_req.valid;
    wire logic v_step = v_op && flow_req.op == pcsi_pkg::PCSI_OP_STEP;
    wire logic v_jump = v_op && flow_req.op == pcsi_pkg::PCSI_OP_JUMP;
    wire logic v_call = v_op && flow_req.op == pcsi_pkg::PCSI_OP_CALL;
    wire logic v_ret  = v_op && flow_req.op == pcsi_pkg::PCSI_OP_RET;
    wire logic v_irq  = v_op && flow_req.op == pcsi_pkg::PCSI_OP_IRQ;
    wire logic v_lwr  = v_op && flow_req.op == pcsi_pkg::PCSI_OP_LOWWR;
    wire logic v_ladd = v_op && flow_req.op == pcsi_pkg::PCSI_OP_LOWADD;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // reset must be seen: no disable
    AST_RESET_CLEARS: assert property (disable iff (1'b0) !aresetn |=> pc_value == 13'h0000)
        else $error("pc not cleared");
    AST_STEP_INC: assert property (v_step |=> pc_value == $past(pc_value) + 13'h0001)
        else $error("step wrong");
    AST_TARGET_LOW: assert property ((v_jump || v_call) |=> pc_value[10:0] == $past(flow_req.target))
        else $error("target wrong");
    AST_LOWWR_BYTE: assert property (v_lwr |=> pc_value[7:0] == $past(flow_req.data))
        else $error("lowwr wrong");
    AST_LOWADD_WRAP: assert property (v_ladd |=> pc_value[7:0] == $past(pc_value[7:0]) + $past(flow_req.data))
        else $error("lowadd wrong");
    AST_IRQ_VECTOR: assert property (v_irq |=> pc_value == `PCSI_IRQ_VECTOR)
        else $error("no vector");
    AST_CALL_RETURN: assert property (v_call ##1 v_ret |=> pc_value == $past(pc_value, 2) + 13'h0001)
        else $error("call return wrong");
    AST_IRQ_RETURN: assert property (v_irq ##1 v_ret |=> pc_value == $past(pc_value, 2))
        else $error("irq return wrong");
    AST_DIRECT_ADDR: assert property (!daddr_req.indirect |-> daddr.addr[6:0] == daddr_req.location && !daddr.read_zero)
        else $error("direct addr wrong");
    AST_SELF_FLAGS: assert property ((daddr.read_zero || daddr.write_block) |-> daddr.read_zero && daddr.write_block && daddr_req.indirect && daddr.addr[6:0] == 7'h00)
        else $error("self flags wrong");

    cover property (v_call ##1 v_ret);
    cover property (v_irq ##1 v_ret);
    cover property (daddr.read_zero);
endmodule // pcsi_core_props

bind pcsi_core pcsi_core_props u_props (.aclk(aclk), .aresetn(aresetn), .flow_req(flow_req),
    .pc_value(pc_value), .daddr_req(daddr_req), .daddr(daddr));

// ==== test/pcsi_decode_model.sv ====
// instruction decode stand-in driving flow and data address requests
`timescale 1ns/1ps
module pcsi_decode_model (
    output pcsi_pkg::pcsi_flow_req_t  flow_req,
    output pcsi_pkg::pcsi_daddr_req_t daddr_req,
    input  wire logic                 aclk
);
    initial
    begin
        flow_req  = '0;
        daddr_req = '0;
    end
    // consecutive calls keep valid up, giving back-to-back ops
    task automatic issue(input pcsi_pkg::pcsi_op_t o, input logic [10:0] t, input logic [7:0] d);
        @(posedge aclk);
        flow_req <= '{1'b1, o, t, d};
    endtask
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            flow_req.valid <= 1'b0;
        end
    endtask
    task automatic set_daddr(input logic ind, input logic [6:0] loc);
        @(posedge aclk);
        daddr_req <= '{ind, loc};
    endtask
endmodule // pcsi_decode_model

// ==== test/testbench.sv ====
// self-checking bench for the program counter and addressing unit
`timescale 1ns/1ps
`include "pcsi_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module testbench;
    logic                      aclk;
    logic                      aresetn;
    logic                      s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]                s_axi_awaddr, s_axi_araddr, e_lat, e_fsel, e_bank;
    logic [31:0]               s_axi_wdata, r;
    logic [3:0]                s_axi_wstrb;
    wire logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]           s_axi_bresp, s_axi_rresp;
    wire logic [31:0]          s_axi_rdata;
    pcsi_pkg::pcsi_flow_req_t  flow_req;
    pcsi_pkg::pcsi_daddr_req_t daddr_req;
    wire logic [12:0]          pc_value;
    pcsi_pkg::pcsi_daddr_t     daddr;
    logic [12:0]               e_pc;
    logic [12:0]               e_stk [8];
    logic [2:0]                e_sp;
    logic                      watch;
    integer                    seed, errors, checked, i;

    pcsi_core dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .flow_req, .pc_value, .daddr_req, .daddr);
    pcsi_decode_model u_dec (.aclk, .flow_req, .daddr_req);

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ************************************************************
    // reference model
    // ************************************************************
    function automatic logic [12:0] nxt_pc(pcsi_pkg::pcsi_flow_req_t q, logic [12:0] p, logic [7:0] l, logic [12:0] top);
        case (q.op)
            pcsi_pkg::PCSI_OP_STEP:  return p + 13'h0001;
            pcsi_pkg::PCSI_OP_RET:   return top;
            pcsi_pkg::PCSI_OP_IRQ:   return `PCSI_IRQ_VECTOR;
            pcsi_pkg::PCSI_OP_LOWWR: return {l[4:0], q.data};
            pcsi_pkg::PCSI_OP_LOWADD: return {l[4:0], 8'(p[7:0] + q.data)};
            default:                 return {l[4:3], q.target};
        endcase
    endfunction
    function automatic logic [31:0] exp_rd(logic [7:0] a);
        case (a)
            8'h00: return {24'h0, e_pc[7:0]};
            8'h04: return {24'h0, e_lat};
            8'h08: return {24'h0, e_fsel};
            8'h0C: return {24'h0, e_bank & 8'hE0};
            8'h10: return {19'h0, e_pc};
            default: return 32'h0;
        endcase
    endfunction
    // stack contents survive reset, only the pointer clears
    always @(posedge aclk)
        if (!aresetn)
        begin
            e_pc <= 13'h0000;
            e_sp <= 3'h0;
            e_lat <= 8'h00;
            e_fsel <= 8'h00;
            e_bank <= 8'h00;
        end
        else if (flow_req.valid)
        begin
            e_pc <= nxt_pc(flow_req, e_pc, e_lat, e_stk[e_sp - 3'h1]);
            if (flow_req.op inside {pcsi_pkg::PCSI_OP_CALL, pcsi_pkg::PCSI_OP_IRQ})
            begin
                e_stk[e_sp] <= (flow_req.op == pcsi_pkg::PCSI_OP_IRQ) ? e_pc : e_pc + 13'h0001;
                e_sp <= e_sp + 3'h1;
            end
            if (flow_req.op == pcsi_pkg::PCSI_OP_RET)
                e_sp <= e_sp - 3'h1;
        end
    always @(negedge aclk)
        if (watch)
            `CHK(pc_value, e_pc)

    // ************************************************************
    // register bus tasks
    // ************************************************************
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        watch = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        if (n >= 100) errors++;
        `CHK(s_axi_bresp, (a <= 8'h10) ? 2'h0 : 2'h2)
        if (s[0])
            case (a)
                8'h00: e_pc = {e_lat[4:0], d[7:0]};
                8'h04: e_lat = d[7:0];
                8'h08: e_fsel = d[7:0];
                8'h0C: e_bank = d[7:0];
                default: ;
            endcase
        watch = 1'b1;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        if (n >= 100) errors++;
        `CHK(s_axi_rresp, (a <= 8'h10) ? 2'h0 : 2'h2)
        `CHK(s_axi_rdata, exp_rd(a))
    endtask
    task automatic dchk(input logic ind, input logic [6:0] loc);
        logic z;
        z = ind && e_fsel[6:0] == 7'h00;
        u_dec.set_daddr(ind, loc);
        @(negedge aclk);
        `CHK(daddr, pcsi_pkg::pcsi_daddr_t'({ind ? {e_bank[7], e_fsel} : {e_bank[6:5], loc}, z, z}))
    endtask
    task automatic conclude;
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        conclude;
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        seed = 6;
        errors = 0;
        checked = 0;
        watch = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        watch = 1'b1;
        reg_rd(8'h10);
        reg_wr(8'h04, 32'h18, 4'hF);
        u_dec.issue(pcsi_pkg::PCSI_OP_JUMP, 11'h123, 8'h00);
        u_dec.issue(pcsi_pkg::PCSI_OP_CALL, 11'h7FF, 8'h00);
        u_dec.issue(pcsi_pkg::PCSI_OP_LOWWR, 11'h000, 8'hF0);
        u_dec.issue(pcsi_pkg::PCSI_OP_LOWADD, 11'h000, 8'h20);
        u_dec.issue(pcsi_pkg::PCSI_OP_IRQ, 11'h000, 8'h00);
        repeat (2) u_dec.issue(pcsi_pkg::PCSI_OP_RET, 11'h000, 8'h00);
        // ten deep: two entries overwritten
        for (i = 0; i < 10; i++) u_dec.issue(pcsi_pkg::PCSI_OP_CALL, 11'(i * 8'h51), 8'h00);
        for (i = 0; i < 10; i++) u_dec.issue(pcsi_pkg::PCSI_OP_RET, 11'h000, 8'h00);
        u_dec.idle(1);
        reg_rd(8'h04);
        reg_wr(8'h10, 32'h1ABC, 4'hF);
        reg_wr(8'h00, 32'h5A, 4'hE);
        reg_wr(8'h00, 32'hA5, 4'hF);
        reg_wr(8'h18, 32'h77, 4'hF);
        reg_rd(8'h1C);
        for (i = 0; i < 300; i++)
        begin
            r = $random(seed);
            if (r[4:3] == 2'h0)
            begin
                u_dec.idle(1);
                reg_wr({3'h0, r[12:10], 2'h0}, $random(seed), 4'hF);
            end
            else if (r[4:3] == 2'h1)
            begin
                u_dec.idle(1);
                reg_rd({3'h0, r[12:10], 2'h0});
            end
            else
            begin
                u_dec.issue(pcsi_pkg::pcsi_op_t'((r[2:0] == 3'h7) ? 3'h0 : r[2:0]), r[23:13], r[31:24]);
                if (r[5]) u_dec.idle(r[7:6]);
            end
        end
        u_dec.idle(1);
        for (i = 0; i < 40; i++)
        begin
            r = $random(seed);
            reg_wr(8'h08, (i < 2) ? {24'h0, i[0], 7'h00} : r, 4'hF);
            reg_wr(8'h0C, r >> 8, 4'hF);
            dchk(1'b1, r[22:16]);
            dchk(1'b0, r[30:24]);
        end
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        u_dec.issue(pcsi_pkg::PCSI_OP_RET, 11'h000, 8'h00);
        u_dec.issue(pcsi_pkg::PCSI_OP_STEP, 11'h000, 8'h00);
        u_dec.idle(2);
        reg_rd(8'h10);
        conclude;
    end
endmodule // testbench
